// [src/initial_reset_generator.sv]
// initial reset generator: pin latch, key reset, cpu reset state, ports
// assumes ref_clk is the oscillator clock and software on Avalon-MM
//
// Contract
// RULE1: pin held low resets the device; cpu runs after release
// RULE2: latch holds pin reset, cleared on rising edge of clock/1048576
// RULE3: board holds pin low at least 0.1 ms while running
// RULE4: at power-up board holds pin low past supply valid plus 100 us
// RULE5: key reset fires when all keys of chosen combination are low
// RULE6: key pulses shorter than 256*n clocks are rejected as noise
// RULE7: board holds keys low at least three noise widths
// RULE8: board holds keys low through filter time after oscillation starts
// RULE9: optional authorise needs 524288*n to 1048576*n clocks low
// RULE10: in sleep the key reset bypasses filter and authorise
// RULE11: reset loads pc with 0110H, clears interrupt and extension flags
// RULE12: data, index, stack registers and memories are left undefined
// RULE13: interrupts masked until both stack pointers are written
// RULE14: extension register write sets extension flag for next step
// RULE15: reset makes outputs drive high and shared pins pulled inputs; io_pullup_en stays 00 while rst_i_n is low, pull-ups come on at the next clock
// RULE16: internal reset is pin latch or qualified key reset
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`include "reset_gen_regs.svh"

module initial_reset_generator #(
   parameter int         RELEASE_DIV = `RELEASE_DIV,
   parameter int         NOISE_TICKS = `NOISE_TICKS,
   parameter int         AUTH_TICKS  = `AUTH_TICKS,
   parameter logic [7:0] PULLUP_MASK = `PULLUP_RESET
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // board pins
   input  wire logic        reset_pin_n,
   input  wire logic [3:0]  key_inputs,
   // cpu side
   input  wire logic        instr_retire,
   output logic             init_reset,
   output logic [15:0]      program_counter,
   output logic             interrupt_flag,
   output logic             extension_flag,
   output logic             interrupts_masked,
   // shared port pins
   output logic [3:0]       output_port_pins,
   output logic [7:0]       io_out,
   output logic [7:0]       io_oe_n,
   output logic [7:0]       io_pullup_en
);

   localparam int RW   = $clog2(RELEASE_DIV);
   localparam int HALF = RELEASE_DIV / 2;

   // ==========================================================
   // elaboration check
   if (RELEASE_DIV < 4 || (RELEASE_DIV % 2) != 0)
   begin : g_bad
      $error("initial_reset_generator: RELEASE_DIV must be even, >= 4");
   end

   // ==========================================================
   // reset release and pin synchronisers
   logic [1:0] rst_sync_q;
   wire logic  rst_i_n = rst_sync_q[1];
   logic       pin_s1_q;
   logic       pin_s2_q;
   logic [3:0] key_s1_q;
   logic [3:0] key_s2_q;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   // pin reads low until sampled, keeping reset asserted; keys read up
   always_ff @(posedge ref_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         key_s1_q <= 4'hF;
         key_s2_q <= 4'hF;
      end
      else
      begin
         pin_s1_q <= reset_pin_n;
         pin_s2_q <= pin_s1_q;
         key_s1_q <= key_inputs;
         key_s2_q <= key_s1_q;
      end
   end

   // ==========================================================
   // release divider and reset latch
   logic [RW-1:0] rel_cnt_q;
   logic          pin_latch_q;
   wire logic     rel_wrap = (rel_cnt_q == RW'(RELEASE_DIV - 1));
   wire logic     rel_rise = (rel_cnt_q == RW'(HALF - 1));  // see RULE2
   wire logic [RW-1:0] rel_cnt_d = rel_wrap ? '0 : rel_cnt_q + RW'(1);

   // low pin sets; set wins over a coincident release edge
   wire logic pin_latch_d = !pin_s2_q ? 1'b1                 // see RULE1
                          : (rel_rise ? 1'b0 : pin_latch_q); // see RULE2

   always_ff @(posedge ref_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         rel_cnt_q   <= '0;
         pin_latch_q <= 1'b1;
      end
      else
      begin
         rel_cnt_q   <= rel_cnt_d;
         pin_latch_q <= pin_latch_d;
      end
   end

   // ==========================================================
   // configuration registers
   reset_gen_pkg::ctrl_t ctrl_q;
   reset_gen_pkg::port_t port_q;
   logic                 key_rst;

   key_reset_qualifier #(
      .NOISE_TICKS (NOISE_TICKS),
      .AUTH_TICKS  (AUTH_TICKS)
   ) u_key (
      .clk       (ref_clk),
      .rst_n     (rst_i_n),
      .combo     (ctrl_q.combo),
      .auth_en   (ctrl_q.auth_en),
      .sleep     (ctrl_q.sleep),
      .prescale  (ctrl_q.prescale),
      .key_n     (key_s2_q),
      .key_reset (key_rst)
   );

   wire logic init_reset_d = pin_latch_q | key_rst;         // see RULE16

   // ==========================================================
   // bus decode
   wire logic req      = avs_read | avs_write;
   wire logic accept   = req & !avs_waitrequest;
   wire logic wr       = accept & avs_write;
   wire logic sel_ctrl = (avs_address == `OFS_CTRL);
   wire logic sel_stat = (avs_address == `OFS_STATUS);
   wire logic sel_wsp  = (avs_address == `OFS_WIDE_SP);
   wire logic sel_nsp  = (avs_address == `OFS_NIBBLE_SP);
   wire logic sel_ext  = (avs_address == `OFS_EXT);
   wire logic sel_pc   = (avs_address == `OFS_PC);
   wire logic sel_port = (avs_address == `OFS_PORT);
   // cpu-side writes are ignored while reset holds the cpu
   wire logic wr_cpu   = wr & !init_reset;
   wire logic wr_wsp   = wr_cpu & sel_wsp;
   wire logic wr_nsp   = wr_cpu & sel_nsp;
   wire logic wr_ext   = wr_cpu & sel_ext;

   always_ff @(posedge ref_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         ctrl_q <= reset_gen_pkg::ctrl_t'(`CTRL_RESET);
         port_q <= reset_gen_pkg::port_t'(`PORT_RESET);
      end
      else
      begin
         if (wr & sel_ctrl)
            ctrl_q <= reset_gen_pkg::ctrl_t'(avs_writedata[`CTRL_W-1:0]);
         if (init_reset)
            port_q <= reset_gen_pkg::port_t'(`PORT_RESET);  // see RULE15
         else if (wr & sel_port)
            port_q <= reset_gen_pkg::port_t'(avs_writedata[`PORT_W-1:0]);
      end
   end

   // ==========================================================
   // cpu state held by the initial reset
   // pointer values carry no reset: contents undefined after reset
   logic [9:0]  wide_stack_pointer_q;                        // see RULE12
   logic [7:0]  nibble_stack_pointer_q;                      // see RULE12
   logic [7:0]  address_extension_register_q;                // see RULE12
   logic        wsp_set_q;
   logic        nsp_set_q;

   always_ff @(posedge ref_clk)
   begin
      if (wr_wsp)
         wide_stack_pointer_q <= avs_writedata[9:0];
      if (wr_nsp)
         nibble_stack_pointer_q <= avs_writedata[7:0];
      if (wr_ext)
         address_extension_register_q <= avs_writedata[7:0];
   end

   // rewriting one pointer of a set pair masks again until the other
   wire logic both_set = wsp_set_q & nsp_set_q;
   wire logic wsp_set_d = wr_wsp | (wsp_set_q & !(wr_nsp & both_set));
   wire logic nsp_set_d = wr_nsp | (nsp_set_q & !(wr_wsp & both_set));

   // extension flag lives for one retired instruction after the write
   wire logic ext_flag_d = wr_ext ? 1'b1                     // see RULE14
                         : (instr_retire ? 1'b0 : extension_flag);
   wire logic irq_flag_d = (wr & sel_ctrl)
                         ? avs_writedata[`CTRL_W-1] : interrupt_flag;
   wire logic [15:0] pc_d = instr_retire ? program_counter + 16'h0001
                                         : program_counter;

   always_ff @(posedge ref_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         init_reset        <= 1'b1;
         program_counter   <= `PC_RESET;
         interrupt_flag    <= 1'b0;
         extension_flag    <= 1'b0;
         wsp_set_q         <= 1'b0;
         nsp_set_q         <= 1'b0;
         interrupts_masked <= 1'b1;
      end
      else
      begin
         init_reset <= init_reset_d;                         // see RULE16
         if (init_reset)
         begin
            program_counter   <= `PC_RESET;                  // see RULE11
            interrupt_flag    <= 1'b0;                       // see RULE11
            extension_flag    <= 1'b0;                       // see RULE11
            wsp_set_q         <= 1'b0;                       // see RULE13
            nsp_set_q         <= 1'b0;                       // see RULE13
            interrupts_masked <= 1'b1;                       // see RULE13
         end
         else
         begin
            program_counter   <= pc_d;                       // see RULE1
            interrupt_flag    <= irq_flag_d;
            extension_flag    <= ext_flag_d;
            wsp_set_q         <= wsp_set_d;
            nsp_set_q         <= nsp_set_d;
            interrupts_masked <= !(wsp_set_d & nsp_set_d);   // see RULE13
         end
      end
   end

   // ==========================================================
   // shared pins
   // output pins high and io pins undriven while reset holds
   wire logic [7:0] io_dir_eff = init_reset ? 8'h00 : port_q.io_dir;
   wire logic [7:0] oe_n_d = ~io_dir_eff;                    // see RULE15
   wire logic [7:0] pull_d = ~io_dir_eff & PULLUP_MASK;      // see RULE15
   wire logic [3:0] out_d  = init_reset ? 4'hF : port_q.out_data;

   always_ff @(posedge ref_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         output_port_pins <= 4'hF;
         io_out           <= 8'h00;
         io_oe_n          <= 8'hFF;
         io_pullup_en     <= 8'h00;
      end
      else
      begin
         output_port_pins <= out_d;
         io_out           <= port_q.io_data;
         io_oe_n          <= oe_n_d;
         io_pullup_en     <= pull_d;
      end
   end

   // ==========================================================
   // read mux and handshake: one wait state per access
   reset_gen_pkg::status_t status;
   assign status = '{irq_flag:   interrupt_flag,
                     ext_flag:   extension_flag,
                     irq_masked: interrupts_masked,
                     key_rst:    key_rst,
                     pin_rst:    pin_latch_q};

   wire logic [31:0] rd_d =
        sel_ctrl ? {23'h000000, ctrl_q}
      : sel_stat ? {27'h0000000, status}
      : sel_pc   ? {16'h0000, program_counter}
      : sel_port ? {12'h000, port_q}
      :            32'h00000000;

   always_ff @(posedge ref_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end
      else if (req && avs_waitrequest)
      begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? rd_d : 32'h00000000;
      end
      else
         avs_waitrequest <= 1'b1;
   end

endmodule : initial_reset_generator

// [src/reset_gen_regs.svh]
// register offsets, reset values and timing counts of the reset generator
// assumes byte addressing on a 32-bit Avalon-MM slave port
`ifndef RESET_GEN_REGS_SVH
`define RESET_GEN_REGS_SVH

// ==========================================================
// register byte offsets
`define OFS_CTRL       5'h00
`define OFS_STATUS     5'h04
`define OFS_WIDE_SP    5'h08
`define OFS_NIBBLE_SP  5'h0C
`define OFS_EXT        5'h10
`define OFS_PC         5'h14
`define OFS_PORT       5'h18

// ==========================================================
// field widths and reset values
`define CTRL_W         9
`define PORT_W         20
`define STATUS_W       5
`define CTRL_RESET     9'h01F
`define PORT_RESET     20'h0000F
`define PC_RESET       16'h0110
`define PULLUP_RESET   8'hFF

// ==========================================================
// timing counts in oscillator periods (key counts are per n)
`define RELEASE_DIV    1048576
`define NOISE_TICKS    256
`define AUTH_TICKS     524288

`endif

// [src/reset_gen_pkg.sv]
// types shared by the reset generator and its key qualifier
// assumes the constants header is compiled alongside
package reset_gen_pkg;

   // ==========================================================
   // key combination options
   typedef enum logic [1:0] {
      COMBO_OFF   = 2'b00,
      COMBO_K0123 = 2'b01,
      COMBO_K012  = 2'b10,
      COMBO_K01   = 2'b11
   } key_combo_t;

   // ==========================================================
   // key qualifier states
   typedef enum logic [1:0] {
      KQ_IDLE   = 2'b00,
      KQ_FILTER = 2'b01,
      KQ_AUTH   = 2'b10,
      KQ_FIRED  = 2'b11
   } kq_state_t;

   // ==========================================================
   // register layouts
   typedef struct packed {
      logic       irq_enable;
      logic       sleep;
      logic       auth_en;
      key_combo_t combo;
      logic [3:0] prescale;
   } ctrl_t;

   typedef struct packed {
      logic [7:0] io_dir;
      logic [7:0] io_data;
      logic [3:0] out_data;
   } port_t;

   typedef struct packed {
      logic irq_flag;
      logic ext_flag;
      logic irq_masked;
      logic key_rst;
      logic pin_rst;
   } status_t;

endpackage : reset_gen_pkg

// [src/key_reset_qualifier.sv]
// qualifies the simultaneous-low key combination into a reset request
// assumes synchronised active-low keys and an asynchronous active-low reset
`timescale 1ns/1ns
`include "reset_gen_regs.svh"

module key_reset_qualifier #(
   parameter int NOISE_TICKS = `NOISE_TICKS,
   parameter int AUTH_TICKS  = `AUTH_TICKS
) (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // configuration
   input  wire reset_gen_pkg::key_combo_t  combo,
   input  wire logic                       auth_en,
   input  wire logic                       sleep,
   input  wire logic [3:0]                 prescale,
   // keys, low when pressed
   input  wire logic [3:0]                 key_n,
   // qualified request
   output logic                            key_reset
);

   localparam int CW = 20;

   // ==========================================================
   // elaboration check
   if (NOISE_TICKS < 1 || AUTH_TICKS <= NOISE_TICKS ||
       AUTH_TICKS > (1 << CW))
   begin : g_bad
      $error("key_reset_qualifier: tick counts out of range");
   end

   // ==========================================================
   // combination decode
   wire logic all4  = ~|key_n;
   wire logic first3 = ~|key_n[2:0];
   wire logic first2 = ~|key_n[1:0];
   logic      combo_low;

   always_comb
   begin
      case (combo)
         reset_gen_pkg::COMBO_K0123: combo_low = all4;   // see RULE5
         reset_gen_pkg::COMBO_K012:  combo_low = first3; // see RULE5
         reset_gen_pkg::COMBO_K01:   combo_low = first2; // see RULE5
         default:                    combo_low = 1'b0;
      endcase
   end

   // ==========================================================
   // prescaler tick every n = setting + 1 cycles
   logic [3:0] pre_q;
   wire logic  tick = (pre_q == prescale);
   wire logic [3:0] pre_d = tick ? 4'h0 : pre_q + 4'h1;

   // ==========================================================
   // filter and authorise sequence
   reset_gen_pkg::kq_state_t state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   wire logic noise_done = tick && (cnt_q == CW'(NOISE_TICKS - 1));
   wire logic auth_done  = tick && (cnt_q == CW'(AUTH_TICKS - 1));
   wire logic [CW-1:0] cnt_inc = tick ? cnt_q + CW'(1) : cnt_q;

   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_inc;
      case (state_q)
         reset_gen_pkg::KQ_IDLE:
         begin
            cnt_d = '0;
            if (combo_low)
               state_d = reset_gen_pkg::KQ_FILTER;
         end
         reset_gen_pkg::KQ_FILTER:
         begin
            // short pulses fall back to idle
            if (!combo_low)
               state_d = reset_gen_pkg::KQ_IDLE;        // see RULE6
            else if (noise_done)
            begin
               cnt_d   = '0;
               state_d = auth_en ? reset_gen_pkg::KQ_AUTH
                                 : reset_gen_pkg::KQ_FIRED;
            end
         end
         reset_gen_pkg::KQ_AUTH:
         begin
            if (!combo_low)
               state_d = reset_gen_pkg::KQ_IDLE;        // see RULE9
            else if (auth_done)
               state_d = reset_gen_pkg::KQ_FIRED;       // see RULE9
         end
         reset_gen_pkg::KQ_FIRED:
         begin
            cnt_d = '0;
            if (!combo_low)
               state_d = reset_gen_pkg::KQ_IDLE;
         end
         default:
         begin
            cnt_d   = '0;
            state_d = reset_gen_pkg::KQ_IDLE;
         end
      endcase
   end

   // oscillator stopped in sleep: filter and timer are skipped
   wire logic key_reset_d = sleep ? combo_low                // see RULE10
                          : (state_d == reset_gen_pkg::KQ_FIRED);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_q     <= 4'h0;
         cnt_q     <= '0;
         state_q   <= reset_gen_pkg::KQ_IDLE;
         key_reset <= 1'b0;
      end
      else
      begin
         pre_q     <= pre_d;
         cnt_q     <= cnt_d;
         state_q   <= state_d;
         key_reset <= key_reset_d;
      end
   end

endmodule : key_reset_qualifier

// [bench/reset_gen_sva.sv]
// checker for the reset generator, watching top-level ports only
// assumes it is bound to the design from the bench top file
`timescale 1ns/1ns
`include "reset_gen_regs.svh"

module reset_gen_sva #(
   parameter int RELEASE_DIV = 16
) (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // bus and board
   input wire logic [4:0]  avs_address,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic        reset_pin_n,
   input wire logic [3:0]  key_inputs,
   input wire logic        instr_retire,
   // cpu and port outputs
   input wire logic        init_reset,
   input wire logic [15:0] program_counter,
   input wire logic        interrupt_flag,
   input wire logic        extension_flag,
   input wire logic        interrupts_masked,
   input wire logic [3:0]  output_port_pins,
   input wire logic [7:0]  io_oe_n
);
   // ==========================================================
   // quiet time: pin high and no key down
   // slack covers both synchronisers and one whole release period
   localparam int QUIET_LIM = RELEASE_DIV + 8;
   int quiet_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         quiet_q <= 0;
      else if (!reset_pin_n || key_inputs != 4'hF)
         quiet_q <= 0;
      else if (quiet_q != QUIET_LIM)
         quiet_q <= quiet_q + 1;
   end

   // ==========================================================
   // assertions
   a_pin_holds:
      assert property (!reset_pin_n [*4] |-> ##[0:2] init_reset)
      else $error("pin low without reset");
   a_latch_release:
      assert property (quiet_q == QUIET_LIM |-> !init_reset)
      else $error("reset outlived release");
   a_cpu_reset_state:
      assert property (init_reset [*2] |-> program_counter == 16'h0110
                       && !interrupt_flag && !extension_flag)
      else $error("cpu state in reset");
   a_irq_masked:
      assert property (init_reset [*2] |-> interrupts_masked)
      else $error("irq not masked in reset");
   a_port_default:
      assert property (init_reset [*2] |->
                       output_port_pins == 4'hF && io_oe_n == 8'hFF)
      else $error("ports not default in reset");
   a_pc_steps:
      assert property (!init_reset && instr_retire ##1 !init_reset |->
                       program_counter == $past(program_counter) + 16'h0001)
      else $error("pc did not advance on retire");
   a_ext_sets:
      assert property (avs_write && !avs_waitrequest && !init_reset &&
                       avs_address == `OFS_EXT |=> extension_flag)
      else $error("ext flag not set");
   a_ext_clears:
      assert property (extension_flag && instr_retire ##1 !init_reset
                       |-> !extension_flag)
      else $error("ext flag not cleared");

   c_released: cover property ($fell(init_reset) && reset_pin_n);
   c_ext_used: cover property ($fell(extension_flag));
   c_unmasked: cover property ($fell(interrupts_masked));
endmodule : reset_gen_sva

// [bench/board_model.sv]
// board side: reset supervisor on the pin, keys on the input port
// assumes the bench pulses pin_req and sets keys_down on clock edges
`timescale 1ns/1ns

module board_model #(
   parameter int MIN_LOW = 10000
) (
   // clock
   input  wire logic       clk,
   // bench commands
   input  wire logic       pin_req,
   input  wire logic [3:0] keys_down,
   // board pins
   output logic            reset_pin_n,
   output logic [3:0]      key_inputs
);
   // supervisor holds the pin from power-up, so the count starts full
   int hold_q = MIN_LOW;

   always @(posedge clk)
   begin
      if (pin_req)
         hold_q <= MIN_LOW;
      else if (hold_q != 0)
         hold_q <= hold_q - 1;
   end

   assign reset_pin_n = (hold_q == 0);
   // lifted keys are pulled up, so they read high at once
   assign key_inputs  = ~keys_down;
endmodule : board_model

// [bench/initial_reset_generator_tb_top.sv]
// self-checking bench for the initial reset generator
// assumes board_model and reset_gen_sva are compiled before this file
`timescale 1ns/1ns
`include "reset_gen_regs.svh"

module initial_reset_generator_tb_top;
   // shortened counts keep the run near twenty thousand cycles
   localparam int RD  = 16;
   localparam int NT  = 4;
   localparam int AT  = 32;
   localparam int LOW = 10000;

   logic        ref_clk = 1'b0, rst_n = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic        pin_req = 1'b0, reset_pin_n, instr_retire = 1'b0;
   logic [3:0]  keys_down = 4'h0, key_inputs, output_port_pins;
   logic        init_reset, interrupt_flag, extension_flag;
   logic        interrupts_masked;
   logic [15:0] program_counter;
   logic [7:0]  io_out, io_oe_n, io_pullup_en;
   int          n_fail = 0;
   int          n_checks = 0;

   always #5 ref_clk = ~ref_clk;

   board_model #(.MIN_LOW(LOW)) board_model_inst (.clk(ref_clk), .*);

   initial_reset_generator #(.RELEASE_DIV(RD), .NOISE_TICKS(NT),
      .AUTH_TICKS(AT)) initial_reset_generator_inst (.*);

   // ==========================================================
   // shared tasks
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int t = 0;
      tick(1);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= !wr;
      avs_write     <= wr;
      do
      begin
         tick(1);
         t++;
      end
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      chk(t, 2, "bus wait");
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic wait_idle(input int lim, output int c);
      c = 0;
      while (init_reset !== 1'b0 && c < lim)
      begin
         tick(1);
         c++;
      end
   endtask : wait_idle

   task automatic chk_reset();
      chk(init_reset, 1'b1, "init reset");
      chk(program_counter, 32'h110, "pc");
      chk({interrupt_flag, extension_flag}, 32'h0, "flags");
      chk(interrupts_masked, 1'b1, "mask");
      chk({output_port_pins, io_oe_n}, 32'hFFF, "ports");
   endtask : chk_reset

   task automatic wait_release();
      int c;
      wait (reset_pin_n === 1'b1);
      tick(1);
      chk(init_reset, 1'b1, "latched");
      wait_idle(RD + 8, c);
      chk(c < RD + 8, 1'b1, "release");
      tick(2);
      chk(io_pullup_en, 8'hFF, "pull-ups");
   endtask : wait_release

   // ==========================================================
   // scenarios
   task automatic t_power();
      tick(20);
      chk_reset();
      wait_release();
      $display("test power done");
   endtask : t_power

   task automatic t_regs();
      logic [4:0]  a [5] = '{`OFS_CTRL, `OFS_STATUS, `OFS_PC, `OFS_PORT,
                             5'h1C};
      logic [31:0] e [5] = '{32'h1F, 32'h4, 32'h110, 32'hF, 32'h0};
      bus(1'b1, `OFS_PC, 32'hFFFF);
      bus(1'b1, 5'h1C, 32'hFFFF);
      for (int i = 0; i < 5; i++)
      begin
         bus(1'b0, a[i], 32'h0);
         chk(rd, e[i], "reset value");
      end
      $display("test regs done");
   endtask : t_regs

   task automatic t_cpu();
      instr_retire <= 1'b1;
      tick(3);
      instr_retire <= 1'b0;
      tick(1);
      chk(program_counter, 32'h113, "pc runs");
      bus(1'b1, `OFS_EXT, 32'h5A);
      tick(1);
      chk(extension_flag, 1'b1, "ext set");
      instr_retire <= 1'b1;
      tick(1);
      instr_retire <= 1'b0;
      tick(1);
      chk(extension_flag, 1'b0, "ext used");
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, i[0] ? `OFS_NIBBLE_SP : `OFS_WIDE_SP, 32'h3);
         tick(2);
         chk(interrupts_masked, !i[0], "sp pair");
      end
      bus(1'b1, `OFS_CTRL, 32'h11F);
      bus(1'b1, `OFS_PORT, 32'h0FA53);
      tick(2);
      chk(interrupt_flag, 1'b1, "irq flag");
      chk({output_port_pins, io_oe_n, io_out, io_pullup_en}, 32'h3F0A5F0,
          "ports set");
      $display("test cpu done");
   endtask : t_cpu

   task automatic t_pin();
      pin_req <= 1'b1;
      tick(1);
      pin_req <= 1'b0;
      tick(8);
      chk_reset();
      wait_release();
      bus(1'b0, `OFS_PORT, 32'h0);
      chk(rd, 32'hF, "port reg");
      $display("test pin done");
   endtask : t_pin

   // hi = 0: no reset allowed
   task automatic key_try(input logic [8:0] ctrl, input logic [3:0] k,
                          input int hold, input int lo, input int hi);
      int seen = -1;
      int c;
      bus(1'b1, `OFS_CTRL, {23'h0, ctrl});
      keys_down <= k;
      for (int i = 0; i < hold + 12; i++)
      begin
         tick(1);
         if (i == hold - 1)
            keys_down <= 4'h0;
         if (seen < 0 && init_reset === 1'b1)
            seen = i;
      end
      wait_idle(40, c);
      chk((hi == 0) ? seen < 0 : (seen >= lo && seen <= hi), 1'b1, "key");
   endtask : key_try

   task automatic t_keys();
      key_try(9'h000, 4'hF, 30, 0, 0);
      key_try(9'h010, 4'h7, 30, 0, 0);
      key_try(9'h010, 4'hF, 30, NT, NT + 10);
      key_try(9'h020, 4'h7, 30, NT, NT + 10);
      key_try(9'h030, 4'h1, 30, 0, 0);
      key_try(9'h030, 4'hB, 30, NT, NT + 10);
      key_try(9'h011, 4'hF, 2 * NT - 2, 0, 0);
      key_try(9'h011, 4'hF, 6 * NT, 2 * NT, 2 * NT + 10);
      key_try(9'h051, 4'hF, 200, 2 * AT, 4 * AT + 18);
      key_try(9'h0DF, 4'hF, 30, 0, 6);
      $display("test keys done");
   endtask : t_keys

   task automatic give_verdict();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   initial
   begin
      tick(12);
      rst_n <= 1'b1;
      t_power();
      t_regs();
      t_cpu();
      t_pin();
      t_keys();
      give_verdict();
   end

   // two pin holds dominate; about twice the run
   initial
   begin
      tick(40000);
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      give_verdict();
   end
endmodule : initial_reset_generator_tb_top

bind initial_reset_generator reset_gen_sva #(.RELEASE_DIV(RELEASE_DIV))
   reset_gen_sva_inst (.*);
